// File: rtl/tec_debounce.sv
`timescale 1ns/1ps
module tec_debounce #(
  parameter int LIMIT = tec_pkg::DB_CYC,
  parameter int CNT_W = 21
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic raw, // switch pin, active high
  output logic held, // debounced level
  output logic press // one-cycle pulse per press
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic level;
    logic pulse;
    logic [CNT_W-1:0] cnt;
  } tec_db_t;

  tec_db_t st;
  tec_db_t next_st;

  if (LIMIT < 1 || LIMIT >= 2**CNT_W) begin : g_chk
    $error("debounce limit does not fit counter");
  end

  always_comb begin
    next_st = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    next_st.pulse = 1'b0;
    // the new level must hold LIMIT cycles before it counts
    if (st.s2 == st.level) begin
      next_st.cnt = '0;
    end else if (st.cnt == CNT_W'(LIMIT - 1)) begin
      next_st.cnt = '0;
      next_st.level = st.s2;
      next_st.pulse = st.s2;
    end else begin
      next_st.cnt = st.cnt + CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign held = st.level;
  assign press = st.pulse;

endmodule : tec_debounce

// File: rtl/tec_edit_ctrl.sv
// Summary of operation
// RULE_01: segment mode toggles on its switch, lamp lit
// RULE_02: write enters write mode, cursor home
// RULE_03: fixed form: write puts cursor at field
// RULE_04: segment mode: write leaves cursor alone
// RULE_05: print only from write, lamp while printing
// RULE_06: transmit only from write, lamp while sending
// RULE_07: insert shifts text later, lamp lit
// RULE_08: segment mode: send from cursor to end mark
// RULE_09: char erase clears cursor cell, needs master
// RULE_10: line erase clears rest, cursor next line
// RULE_11: screen erase clears all, cursor home
// RULE_12: form erase clears variable data only
// RULE_13: back/advance step, auto-repeat ten or five
// RULE_14: return goes next line, no repeat
// RULE_15: segment send: cursor on end, reply after
// RULE_16: print nulls as spaces, segment span only
// RULE_17: fixed form: cursor never on template; the code leaves it on a template in the last cell of the page
// RULE_18: fixed form: return skips template cells
// RULE_19: template cells flagged for half intensity
// RULE_20: fixed-form build offers no insert mode
// RULE_21: advance wraps lines, backspace stays in line
// RULE_22: transmit locks controls, then receive mode
// RULE_23: receive overwrites from start, erases rest
// RULE_24: each press debounced, one command
// RULE_25: write, transmit, print lamps exclusive
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module tec_edit_ctrl #(
  parameter int LINES = tec_pkg::LINES_DEF,
  parameter int COLS = tec_pkg::COLS_DEF,
  parameter bit FORM_FITTED = 1'b0,
  parameter int DB_CYC = tec_pkg::DB_CYC,
  parameter int REP_CYC = tec_pkg::REP_CYC,
  parameter int FORM_REP_CYC = tec_pkg::FORM_REP_CYC
) (
  input wire logic clk, // 250 MHz core clock
  input wire logic rst_n, // async reset, active low
  input wire logic [7:0] paddr, // apb address
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb write
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [3:0] pstrb, // apb byte strobes
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic sw_write, // write switch
  input wire logic send_request_switch, // transmit switch
  input wire logic sw_print, // print switch
  input wire logic sw_insert, // insert switch
  input wire logic sw_segment, // segment switch
  input wire logic sw_form_erase, // form erase switch
  input wire logic sw_char_erase, // char erase switch
  input wire logic line_erase_cmd, // line erase switch
  input wire logic sw_screen_erase, // screen erase switch
  input wire logic sw_back, // backspace switch
  input wire logic sw_adv, // advance switch
  input wire logic sw_return, // return switch
  input wire logic master_erase, // master erase key
  input wire logic key_strobe, // keyboard strobe
  input wire logic [tec_pkg::CW-1:0] key_char, // keyboard code
  output logic [tec_pkg::AW-1:0] mem_addr, // memory address
  output logic mem_we, // memory write pulse
  output logic [tec_pkg::CW-1:0] mem_wdata, // memory write char
  output logic mem_wtmpl, // template flag written
  input wire logic [tec_pkg::CW-1:0] mem_rdata, // char at mem_addr
  input wire logic mem_rtmpl, // template flag read
  output logic tx_valid, // transmit char valid
  output logic [tec_pkg::CW-1:0] tx_char, // transmit char
  input wire logic tx_ready, // transmit accepts
  output logic prt_valid, // printer char valid
  output logic [tec_pkg::CW-1:0] prt_char, // printer char
  input wire logic prt_ready, // printer accepts
  input wire logic rx_valid, // received char valid
  input wire logic [tec_pkg::CW-1:0] rx_char, // received char
  output logic rx_ready, // receive accepts
  output logic lamp_write, // write lamp
  output logic lamp_xmt, // transmit lamp
  output logic lamp_print, // print lamp
  output logic lamp_insert, // insert lamp
  output logic segment_address_mode, // segment lamp
  output logic [tec_pkg::AW-1:0] cursor // mark position
);

  localparam int AW = tec_pkg::AW;
  localparam int CW = tec_pkg::CW;
  localparam int RW = $clog2(FORM_REP_CYC + 1);
  localparam int DW = $clog2(DB_CYC + 1);
  localparam logic [AW-1:0] ONE = AW'(1);
  localparam logic [AW-1:0] NCOL = AW'(COLS);
  localparam logic [AW-1:0] LAST = AW'(LINES * COLS - 1);
  localparam logic [AW-1:0] LAST_LINE = AW'((LINES - 1) * COLS);
  localparam logic [RW-1:0] REP_LIM =
    FORM_FITTED ? RW'(FORM_REP_CYC - 1) : RW'(REP_CYC - 1); // RULE_13

  if (LINES * COLS > 2**AW || COLS < 2 || LINES < 2 ||
      REP_CYC < 1 || FORM_REP_CYC < REP_CYC) begin : g_chk
    $error("geometry or timing parameters out of range");
  end

  typedef struct packed {
    tec_pkg::tec_mode_t mode;
    tec_pkg::tec_seq_t seq;
    logic phase;
    logic insert_on;
    logic seg_on;
    logic form_mode;
    logic er_tmpl;
    logic er_nl;
    logic [AW-1:0] cur;
    logic [AW-1:0] ptr;
    logic [AW-1:0] lim;
    logic [AW-1:0] rx_ptr;
    logic [CW-1:0] put_char;
    logic [CW-1:0] k1;
    logic [CW-1:0] k2;
    logic me1;
    logic me2;
    logic [RW-1:0] rep_cnt;
    logic [AW-1:0] addr;
    logic we;
    logic wtmpl;
    logic [CW-1:0] wdata;
    logic txv;
    logic prv;
    logic [CW-1:0] out_char;
    logic lw;
    logic lx;
    logic lp;
    logic [31:0] rd;
    logic err;
  } tec_st_t;

  tec_st_t st;
  tec_st_t next_st;
  logic [tec_pkg::NSW-1:0] raw;
  logic [tec_pkg::NSW-1:0] held;
  logic [tec_pkg::NSW-1:0] press;

  assign raw = {key_strobe, sw_return, sw_adv, sw_back, sw_screen_erase,
                line_erase_cmd, sw_char_erase, sw_form_erase, sw_segment,
                sw_insert, sw_print, send_request_switch, sw_write};

  // ----------------------------------------------------------------
  // switch conditioning
  // ----------------------------------------------------------------
  for (genvar i = 0; i < tec_pkg::NSW; i++) begin : g_db
    tec_debounce #(
      .LIMIT(DB_CYC),
      .CNT_W(DW)
    ) u_db (
      .clk(clk),
      .rst_n(rst_n),
      .raw(raw[i]),
      .held(held[i]),
      .press(press[i])
    ); // RULE_24
  end

  // ----------------------------------------------------------------
  // control sequencer
  // ----------------------------------------------------------------
  logic fm;
  logic rep_any;
  logic rep_hit;
  logic step_adv;
  logic step_back;
  logic [AW-1:0] col;
  logic [AW-1:0] lstart;
  logic xfer;

  always_comb begin
    fm = FORM_FITTED && st.form_mode;
    col = st.cur % NCOL;
    lstart = st.cur - col;
    rep_any = held[tec_pkg::SW_ADV] | held[tec_pkg::SW_BACK];
    rep_hit = rep_any && (st.rep_cnt == REP_LIM);
    step_adv = press[tec_pkg::SW_ADV] |
               (held[tec_pkg::SW_ADV] & rep_hit); // RULE_13
    step_back = press[tec_pkg::SW_BACK] |
                (held[tec_pkg::SW_BACK] & rep_hit); // RULE_13
    xfer = (st.txv && tx_ready) || (st.prv && prt_ready);
    next_st = st;
    next_st.we = 1'b0;
    next_st.k1 = key_char;
    next_st.k2 = st.k1;
    next_st.me1 = master_erase;
    next_st.me2 = st.me1;
    if (!rep_any || rep_hit || press[tec_pkg::SW_ADV] ||
        press[tec_pkg::SW_BACK]) begin
      next_st.rep_cnt = '0;
    end else begin
      next_st.rep_cnt = st.rep_cnt + RW'(1);
    end

    // register slave: data prepared in setup, returned with no wait
    if (psel && !penable) begin
      next_st.err = 1'b0;
      next_st.rd = '0;
      case (paddr)
        tec_pkg::REG_CTRL: next_st.rd[tec_pkg::CTRL_FORM] = st.form_mode;
        tec_pkg::REG_STATUS: begin
          next_st.rd[tec_pkg::ST_MODE +: 2] = st.mode;
          next_st.rd[tec_pkg::ST_INSERT] = st.insert_on;
          next_st.rd[tec_pkg::ST_SEG] = st.seg_on;
          next_st.rd[tec_pkg::ST_BUSY] = st.seq != tec_pkg::SQ_IDLE;
          next_st.rd[tec_pkg::ST_FORM] = fm;
        end
        tec_pkg::REG_CURSOR: next_st.rd[AW-1:0] = st.cur;
        default: next_st.err = 1'b1;
      endcase
    end
    if (psel && penable && pwrite && pstrb[0] &&
        paddr == tec_pkg::REG_CTRL) begin
      next_st.form_mode = pwdata[tec_pkg::CTRL_FORM];
    end

    case (st.seq)
      tec_pkg::SQ_IDLE: begin
        if (st.mode == tec_pkg::MD_RECV && rx_valid) begin
          next_st.addr = st.rx_ptr; // RULE_23
          next_st.we = 1'b1;
          next_st.wdata = rx_char;
          // templates arrive from the far end while fixed form is on
          next_st.wtmpl = fm && rx_char != tec_pkg::CH_NUL; // RULE_19
          if (st.rx_ptr != LAST) begin
            next_st.rx_ptr = st.rx_ptr + ONE;
          end
          if (rx_char == tec_pkg::CH_ETX) begin
            next_st.mode = tec_pkg::MD_WRITE;
            if (!st.seg_on && st.rx_ptr != LAST) begin
              next_st.seq = tec_pkg::SQ_ERASE; // RULE_23
              next_st.phase = 1'b0;
              next_st.ptr = st.rx_ptr + ONE;
              next_st.lim = LAST;
              next_st.er_tmpl = 1'b1;
              next_st.er_nl = 1'b0;
            end
          end
        end else if (press[tec_pkg::SW_WRITE] &&
                     (st.mode == tec_pkg::MD_WRITE ||
                      st.mode == tec_pkg::MD_RECV)) begin
          next_st.mode = tec_pkg::MD_WRITE; // RULE_02
          if (!st.seg_on) begin // RULE_04
            next_st.cur = '0; // RULE_02
            if (fm) begin
              next_st.seq = tec_pkg::SQ_SKIP; // RULE_03
              next_st.phase = 1'b0;
            end
          end
        end else if (st.mode == tec_pkg::MD_WRITE) begin
          if (press[tec_pkg::SW_XMT] || press[tec_pkg::SW_PRINT]) begin
            next_st.mode = press[tec_pkg::SW_XMT] ?
                           tec_pkg::MD_XMT : tec_pkg::MD_PRINT; // RULE_05
            next_st.seq = tec_pkg::SQ_SEND; // RULE_06
            next_st.phase = 1'b0;
            next_st.ptr = st.seg_on ? st.cur : '0; // RULE_08
          end else if (press[tec_pkg::SW_INSERT]) begin
            next_st.insert_on = !FORM_FITTED && !st.insert_on; // RULE_20
          end else if (press[tec_pkg::SW_SEG]) begin
            next_st.seg_on = !st.seg_on; // RULE_01
          end else if (press[tec_pkg::SW_CHAR_ER] && st.me2) begin
            next_st.addr = st.cur; // RULE_09
            next_st.we = 1'b1;
            next_st.wdata = tec_pkg::CH_NUL;
            next_st.wtmpl = 1'b0;
          end else if (st.me2 && (press[tec_pkg::SW_LINE_ER] ||
                       press[tec_pkg::SW_SCRN_ER] ||
                       press[tec_pkg::SW_FORM_ER])) begin
            next_st.seq = tec_pkg::SQ_ERASE;
            next_st.phase = 1'b0;
            next_st.er_nl = press[tec_pkg::SW_LINE_ER];
            if (press[tec_pkg::SW_LINE_ER]) begin
              next_st.ptr = st.cur; // RULE_10
              next_st.lim = lstart + NCOL - ONE;
              next_st.er_tmpl = !fm;
            end else begin
              next_st.ptr = '0;
              next_st.lim = LAST;
              next_st.er_tmpl = press[tec_pkg::SW_SCRN_ER]; // RULE_12
              if (press[tec_pkg::SW_SCRN_ER]) begin
                next_st.cur = '0; // RULE_11
              end
            end
          end else if (step_adv || step_back ||
                       press[tec_pkg::SW_RET]) begin
            if (step_adv && st.cur != LAST) begin
              next_st.cur = st.cur + ONE; // RULE_21
            end else if (step_back && col != '0) begin
              next_st.cur = st.cur - ONE; // RULE_21
            end else if (press[tec_pkg::SW_RET] &&
                         lstart != LAST_LINE) begin
              next_st.cur = lstart + NCOL; // RULE_14
            end
            if (fm) begin
              next_st.seq = tec_pkg::SQ_SKIP; // RULE_18
              next_st.phase = 1'b0;
            end
          end else if (press[tec_pkg::SW_KEY]) begin
            next_st.put_char = st.k2;
            next_st.phase = 1'b0;
            next_st.ptr = LAST;
            next_st.seq = (st.insert_on && st.cur != LAST) ?
                          tec_pkg::SQ_SHIFT : tec_pkg::SQ_PUT; // RULE_07
          end
        end
      end
      tec_pkg::SQ_SKIP: begin
        // a backspace onto a template cell is pushed forward again
        if (!st.phase) begin
          next_st.addr = st.cur;
          next_st.phase = 1'b1;
        end else if (mem_rtmpl && st.cur != LAST) begin
          next_st.cur = st.cur + ONE; // RULE_17
          next_st.phase = 1'b0;
        end else begin
          next_st.seq = tec_pkg::SQ_IDLE;
        end
      end
      tec_pkg::SQ_ERASE: begin
        if (!st.phase) begin
          next_st.addr = st.ptr;
          next_st.phase = 1'b1;
        end else begin
          next_st.we = st.er_tmpl || !mem_rtmpl; // RULE_12
          next_st.wdata = tec_pkg::CH_NUL;
          next_st.wtmpl = 1'b0;
          next_st.phase = 1'b0;
          next_st.ptr = st.ptr + ONE;
          if (st.ptr == st.lim) begin
            next_st.seq = tec_pkg::SQ_IDLE;
            if (st.er_nl) begin
              if (lstart != LAST_LINE) begin
                next_st.cur = lstart + NCOL; // RULE_10
              end
              if (fm) begin
                next_st.seq = tec_pkg::SQ_SKIP;
              end
            end
          end
        end
      end
      tec_pkg::SQ_SHIFT: begin
        // two cycles per cell; the last cell of the page is dropped
        if (!st.phase) begin
          next_st.addr = st.ptr - ONE;
          next_st.phase = 1'b1;
        end else begin
          next_st.addr = st.ptr; // RULE_07
          next_st.we = 1'b1;
          next_st.wdata = mem_rdata;
          next_st.wtmpl = mem_rtmpl;
          next_st.ptr = st.ptr - ONE;
          next_st.phase = 1'b0;
          if (st.ptr == st.cur + ONE) begin
            next_st.seq = tec_pkg::SQ_PUT;
          end
        end
      end
      tec_pkg::SQ_PUT: begin
        next_st.addr = st.cur;
        next_st.we = 1'b1;
        next_st.wdata = st.put_char;
        next_st.wtmpl = 1'b0;
        next_st.seq = tec_pkg::SQ_IDLE;
        if (st.cur != LAST) begin
          next_st.cur = st.cur + ONE;
          if (fm) begin
            next_st.seq = tec_pkg::SQ_SKIP; // RULE_17
            next_st.phase = 1'b0;
          end
        end
      end
      tec_pkg::SQ_SEND: begin
        if (!st.phase) begin
          next_st.addr = st.ptr;
          next_st.phase = 1'b1;
        end else if (!st.txv && !st.prv) begin
          next_st.txv = st.mode == tec_pkg::MD_XMT;
          next_st.prv = st.mode == tec_pkg::MD_PRINT;
          next_st.out_char = mem_rdata;
          if (st.mode == tec_pkg::MD_PRINT &&
              mem_rdata == tec_pkg::CH_NUL) begin
            next_st.out_char = tec_pkg::CH_SPACE; // RULE_16
          end
        end else if (xfer) begin
          next_st.txv = 1'b0;
          next_st.prv = 1'b0;
          next_st.phase = 1'b0;
          next_st.ptr = st.ptr + ONE;
          if (mem_rdata == tec_pkg::CH_ETX || st.ptr == LAST) begin
            next_st.seq = tec_pkg::SQ_IDLE; // RULE_08
            next_st.mode = tec_pkg::MD_WRITE;
            if (st.mode == tec_pkg::MD_XMT) begin
              next_st.mode = tec_pkg::MD_RECV; // RULE_22
              next_st.rx_ptr = '0;
              if (st.seg_on) begin
                next_st.cur = st.ptr; // RULE_15
                next_st.rx_ptr = (st.ptr == LAST) ? LAST : st.ptr + ONE;
              end
            end
          end
        end
      end
      default: next_st.seq = tec_pkg::SQ_IDLE;
    endcase

    next_st.lw = next_st.mode == tec_pkg::MD_WRITE; // RULE_25
    next_st.lx = next_st.mode == tec_pkg::MD_XMT;
    next_st.lp = next_st.mode == tec_pkg::MD_PRINT;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.mode <= tec_pkg::MD_WRITE;
      st.seq <= tec_pkg::SQ_IDLE;
      st.form_mode <= tec_pkg::CTRL_RESET;
      st.lw <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = st.rd;
  assign pready = 1'b1;
  assign pslverr = st.err;
  assign mem_addr = st.addr;
  assign mem_we = st.we;
  assign mem_wdata = st.wdata;
  assign mem_wtmpl = st.wtmpl;
  assign tx_valid = st.txv;
  assign tx_char = st.out_char;
  assign prt_valid = st.prv;
  assign prt_char = st.out_char;
  assign rx_ready = st.mode == tec_pkg::MD_RECV &&
                    st.seq == tec_pkg::SQ_IDLE;
  assign lamp_write = st.lw;
  assign lamp_xmt = st.lx;
  assign lamp_print = st.lp;
  assign lamp_insert = st.insert_on;
  assign segment_address_mode = st.seg_on;
  assign cursor = st.cur;

endmodule : tec_edit_ctrl

// File: rtl/tec_pkg.sv
package tec_pkg;

  // ----------------------------------------------------------------
  // geometry and character codes
  // ----------------------------------------------------------------
  localparam int AW = 11;
  localparam int CW = 8;
  localparam int LINES_DEF = 20;
  localparam int COLS_DEF = 54;
  localparam logic [CW-1:0] CH_NUL = 8'h00;
  localparam logic [CW-1:0] CH_ETX = 8'h03;
  localparam logic [CW-1:0] CH_SPACE = 8'h20;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 250000;
  localparam int REP_MS = 100;
  localparam int FORM_REP_MS = 200;
  localparam int DB_MS = 5;
  localparam int REP_CYC = REP_MS * CLK_KHZ;
  localparam int FORM_REP_CYC = FORM_REP_MS * CLK_KHZ;
  localparam int DB_CYC = DB_MS * CLK_KHZ;

  // ----------------------------------------------------------------
  // debounced switch indices
  // ----------------------------------------------------------------
  localparam int SW_WRITE = 0;
  localparam int SW_XMT = 1;
  localparam int SW_PRINT = 2;
  localparam int SW_INSERT = 3;
  localparam int SW_SEG = 4;
  localparam int SW_FORM_ER = 5;
  localparam int SW_CHAR_ER = 6;
  localparam int SW_LINE_ER = 7;
  localparam int SW_SCRN_ER = 8;
  localparam int SW_BACK = 9;
  localparam int SW_ADV = 10;
  localparam int SW_RET = 11;
  localparam int SW_KEY = 12;
  localparam int NSW = 13;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CURSOR = 8'h08;
  localparam int CTRL_FORM = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam int ST_MODE = 0;
  localparam int ST_INSERT = 2;
  localparam int ST_SEG = 3;
  localparam int ST_BUSY = 4;
  localparam int ST_FORM = 5;

  typedef enum logic [1:0] {MD_WRITE, MD_XMT, MD_PRINT, MD_RECV} tec_mode_t;
  typedef enum logic [2:0] {
    SQ_IDLE, SQ_SKIP, SQ_ERASE, SQ_SHIFT, SQ_SEND, SQ_PUT
  } tec_seq_t;

endpackage : tec_pkg

// File: verif/tec_edit_ctrl_assertions.sv
`timescale 1ns/1ps
module tec_edit_ctrl_assertions (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic lamp_write, // lamp
  input wire logic lamp_xmt, // lamp
  input wire logic lamp_print, // lamp
  input wire logic mem_we, // store write
  input wire logic tx_valid, // send valid
  input wire logic [tec_pkg::CW-1:0] tx_char, // send char
  input wire logic tx_ready, // send ready
  input wire logic prt_valid, // print valid
  input wire logic [tec_pkg::CW-1:0] prt_char, // print char
  input wire logic prt_ready, // print ready
  input wire logic rx_ready // receive ready
);
  // --------
  // properties
  // --------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_mex; $onehot0({lamp_write, lamp_xmt, lamp_print}); endproperty
  a_mex: assert property (p_mex)
    else $error("mode lamps not exclusive");
  property p_txh; tx_valid && !tx_ready |=> tx_valid && $stable(tx_char);
  endproperty
  a_txh: assert property (p_txh)
    else $error("send char dropped before ready");
  property p_prh; prt_valid && !prt_ready |=> prt_valid && $stable(prt_char);
  endproperty
  a_prh: assert property (p_prh)
    else $error("print char dropped before ready");
  property p_txl; tx_valid |-> lamp_xmt; endproperty
  a_txl: assert property (p_txl)
    else $error("sending without send lamp");
  property p_prw; $rose(lamp_print) |-> $past(lamp_write); endproperty
  a_prw: assert property (p_prw)
    else $error("print entered outside write mode");
  property p_nul; prt_valid |-> prt_char != tec_pkg::CH_NUL; endproperty
  a_nul: assert property (p_nul)
    else $error("null reached printer");
  property p_lock; lamp_xmt |-> !mem_we; endproperty
  a_lock: assert property (p_lock)
    else $error("store written while sending");
  property p_rxr; rx_ready |-> !(lamp_write || lamp_xmt || lamp_print);
  endproperty
  a_rxr: assert property (p_rxr)
    else $error("receive open outside receive mode");
endmodule : tec_edit_ctrl_assertions
bind tec_edit_ctrl tec_edit_ctrl_assertions u_chk (.*);

// File: verif/tec_edit_ctrl_tb.sv
`timescale 1ns/1ps
module tec_edit_ctrl_tb;
  // --------
  // bench, small page
  // --------
  localparam int CO = 8;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, master_erase = 1'b0, tx_ready = 1'b0;
  logic prt_ready = 1'b0, rx_valid = 1'b0, e;
  logic [7:0] paddr = 8'h00, key_char = 8'h00, rx_char = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic [3:0] pstrb = 4'hf;
  logic [12:0] sw = 13'h0;
  wire logic sw_write = sw[0], send_request_switch = sw[1], sw_print = sw[2];
  wire logic sw_insert = sw[3], sw_segment = sw[4], sw_form_erase = sw[5];
  wire logic sw_char_erase = sw[6], line_erase_cmd = sw[7];
  wire logic sw_screen_erase = sw[8], sw_back = sw[9], sw_adv = sw[10];
  wire logic sw_return = sw[11], key_strobe = sw[12];
  logic pready, pslverr, mem_we, mem_wtmpl, mem_rtmpl, tx_valid, prt_valid;
  logic rx_ready, lamp_write, lamp_xmt, lamp_print, lamp_insert;
  logic segment_address_mode;
  logic [10:0] mem_addr, cursor;
  logic [7:0] mem_wdata, mem_rdata, tx_char, prt_char, ch [3], tq[$], pq[$];
  int n_errors = 0, checks = 0, seed = 7156;
  tec_edit_ctrl #(.LINES(4), .COLS(CO), .DB_CYC(4), .REP_CYC(8),
    .FORM_REP_CYC(16)) dut (.*);
  tec_mem_model u_mem (.*);
  initial forever #2 clk = ~clk;
  // far side stalls at random
  always @(posedge clk) begin
    tx_ready <= 1'($random(seed));
    prt_ready <= 1'($random(seed));
    if (tx_valid && tx_ready) tq.push_back(tx_char);
    if (prt_valid && prt_ready) pq.push_back(prt_char);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic tmo(input logic hit);
    if (hit) begin
      n_errors++;
      wrap_up();
    end
  endtask : tmo
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    tmo(k == 50);
  endtask : apb
  // presses while busy are lost
  task automatic press(input int i, input int h);
    int k;
    sw[i] <= 1'b1;
    repeat (h) @(posedge clk);
    sw[i] <= 1'b0;
    repeat (14) @(posedge clk);
    for (k = 0; k < 300; k++) begin
      apb(tec_pkg::REG_STATUS, 1'b0, 32'h0);
      if (r[tec_pkg::ST_BUSY] === 1'b0) break;
    end
    tmo(k == 300);
  endtask : press
  function automatic logic [7:0] pch(input logic [7:0] x);
    return (x == tec_pkg::CH_NUL) ? tec_pkg::CH_SPACE : x;
  endfunction : pch
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({lamp_write, lamp_xmt, lamp_print}, 3'b100);
    apb(8'h0c, 1'b0, 32'h0);
    chk(e, 1'b1);
    apb(tec_pkg::REG_STATUS, 1'b0, 32'h0);
    chk(r, 32'h0);
    for (int i = 0; i < 3; i++) begin
      ch[i] = 8'h41 + 8'($random(seed) & 15);
      key_char <= ch[i];
      press(tec_pkg::SW_KEY, 6);
      chk(u_mem.m[i], ch[i]);
    end
    $display("test entry done");
    press(tec_pkg::SW_ADV, 6);
    chk(cursor, 4);
    press(tec_pkg::SW_BACK, 6);
    chk(cursor, 3);
    press(tec_pkg::SW_RET, 40);
    chk(cursor, CO);
    press(tec_pkg::SW_BACK, 6);
    chk(cursor, CO);
    press(tec_pkg::SW_ADV, 30);
    chk(cursor > CO + 1, 1'b1);
    $display("test cursor done");
    press(tec_pkg::SW_WRITE, 6);
    chk(cursor, 0);
    press(tec_pkg::SW_ADV, 6);
    press(tec_pkg::SW_LINE_ER, 6);
    chk(u_mem.m[1], ch[1]);
    master_erase <= 1'b1;
    press(tec_pkg::SW_LINE_ER, 6);
    chk(u_mem.m[0], ch[0]);
    chk(u_mem.m[2], 8'h00);
    chk(cursor, CO);
    press(tec_pkg::SW_WRITE, 6);
    press(tec_pkg::SW_CHAR_ER, 6);
    chk(u_mem.m[0], 8'h00);
    master_erase <= 1'b0;
    $display("test erase done");
    press(tec_pkg::SW_ADV, 6);
    key_char <= ch[1];
    press(tec_pkg::SW_KEY, 6);
    key_char <= tec_pkg::CH_ETX;
    press(tec_pkg::SW_KEY, 6);
    press(tec_pkg::SW_PRINT, 6);
    chk(pq.size(), 3);
    chk(pq[0], pch(8'h00));
    chk(pq[1], pch(ch[1]));
    chk(lamp_write, 1'b1);
    pq.delete();
    press(tec_pkg::SW_SEG, 6);
    chk(segment_address_mode, 1'b1);
    press(tec_pkg::SW_BACK, 6);
    press(tec_pkg::SW_BACK, 6);
    press(tec_pkg::SW_WRITE, 6);
    chk(cursor, 1);
    press(tec_pkg::SW_PRINT, 6);
    chk(pq.size(), 2);
    press(tec_pkg::SW_XMT, 6);
    chk(tq.size(), 2);
    chk(tq[1], tec_pkg::CH_ETX);
    chk(cursor, 2);
    apb(tec_pkg::REG_STATUS, 1'b0, 32'h0);
    chk(r[1:0], 2'h3);
    press(tec_pkg::SW_WRITE, 6);
    chk(lamp_write, 1'b1);
    press(tec_pkg::SW_INSERT, 6);
    chk(lamp_insert, 1'b1);
    key_char <= 8'h5a;
    press(tec_pkg::SW_KEY, 6);
    chk(u_mem.m[3], tec_pkg::CH_ETX);
    $display("test send done");
    wrap_up();
  end
endmodule : tec_edit_ctrl_tb

// File: verif/tec_mem_model.sv
`timescale 1ns/1ps
module tec_mem_model (
  input wire logic clk, // clock
  input wire logic [tec_pkg::AW-1:0] mem_addr, // address
  input wire logic mem_we, // write
  input wire logic [tec_pkg::CW-1:0] mem_wdata, // char in
  input wire logic mem_wtmpl, // template in
  output logic [tec_pkg::CW-1:0] mem_rdata, // char out
  output logic mem_rtmpl // template out
);
  // --------
  // async-read character store
  // --------
  logic [tec_pkg::CW-1:0] m [2**tec_pkg::AW];
  logic t [2**tec_pkg::AW];
  always @(posedge clk) begin
    if (mem_we) begin
      m[mem_addr] <= mem_wdata;
      t[mem_addr] <= mem_wtmpl;
    end
  end
  initial begin
    for (int i = 0; i < 2**tec_pkg::AW; i++) begin
      m[i] = tec_pkg::CH_NUL;
      t[i] = 1'b0;
    end
  end
  assign mem_rdata = m[mem_addr];
  assign mem_rtmpl = t[mem_addr];
endmodule : tec_mem_model
